// >>> design/pmsc_clk_div.v
/*
  Free-running divider making one-cycle enable pulses of the
  oscillator clock at divide by 2, 4, 8, 16, 32, 64 and 128.
  Assumes one clock, ref_clk, and asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_regs.vh"
module pmsc_clk_div (
  input  wire       ref_clk,
  input  wire       reset_n,
  output reg  [6:0] tick
);
  reg  [`PMSC_DIV_W-1:0] count;
  wire [`PMSC_DIV_W-1:0] next_count;
  wire [`PMSC_DIV_W-1:0] rolled;
  assign next_count = count + `PMSC_DIV_ONE;
  assign rolled     = (~count) & next_count;
  // Counter
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= `PMSC_DIV_ZERO;
    end else begin
      count <= next_count;
    end
  end
  // Bit i rising marks divide by 2^(i+1)
  genvar i;
  generate
    for (i = 0; i < `PMSC_DIV_W; i = i + 1) begin : g_tick
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          tick[i] <= 1'b0;
        end else begin
          tick[i] <= rolled[i];
        end
      end
    end
  endgenerate
endmodule // pmsc_clk_div
`default_nettype wire

// >>> design/pmsc_power_ctrl.v
/*
  Power-mode and sleep control: two system control registers, a
  status register, the sleep-instruction mode transition, standby
  settling wait, medium-speed clock enable and noise sample strobe.
  Assumes a single ref_clk domain, synchronous inputs, and a CPU that
  pulses sleep_exec one cycle and wake_req one cycle.
*/
// Design decision made here: strobed register access.
// How it works
// - Standby clear, sleep in active: sleep, or subactive by direct transfer with the low-speed flag set
// - Standby clear, sleep in subactive: subsleep
// - Standby set, active sleep: standby or watch, or active by direct transfer with the low-speed flag clear
// - Standby set, subactive sleep: watch
// - Wait field picks standby settling count
// - Direct transfer subactive to high-speed active
// - Direct transfer subactive to medium-speed active
// - Noise sample rate osc/16 or osc/4
// - Direct transition sets interrupt request flag
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_regs.vh"
module pmsc_power_ctrl (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       sleep_exec,
  input  wire       wake_req,
  input  wire       timer_a_watch_select,
  output reg  [2:0] power_mode,
  output reg        cpu_clk_en,
  output reg        noise_sample_tick,
  output reg        settling_busy,
  output reg        direct_transition_flag
);
  reg  [7:0]  system_control_one;
  reg  [7:0]  system_control_two;
  reg  [17:0] wait_count;
  reg  [17:0] wait_load;
  reg  [2:0]  next_mode;
  reg         next_direct;
  reg         next_tick;
  reg         next_clk_en;
  wire [6:0]  tick;
  wire        sby  = system_control_one[`PMSC_C1_SBY];
  wire        low_speed_cpu_flag = system_control_one[`PMSC_C1_LOW_SPEED_CPU_FLAG];
  wire        direct_transfer_flag = system_control_two[`PMSC_C2_DT];
  wire        medium_speed_flag = system_control_two[`PMSC_C2_MS];
  wire        in_active = (power_mode == `PMSC_M_ACT_HI) ||
                          (power_mode == `PMSC_M_ACT_MED);
  wire        in_subact = (power_mode == `PMSC_M_SUBACT);
  wire        clr_flag  = reg_wr && (reg_addr == `PMSC_OFS_STATUS) &&
                          !reg_wdata[`PMSC_ST_DTF];
  // Write decode for the two control registers
  wire        wr_ctrl1  = reg_wr && (reg_addr == `PMSC_OFS_CTRL1);
  wire        wr_ctrl2  = reg_wr && (reg_addr == `PMSC_OFS_CTRL2);
  // A wake from standby starts the settling wait
  wire        settle_start = wake_req && (power_mode == `PMSC_M_STANDBY);
  // CPU clock stays off until the oscillator has settled
  wire        settling  = settle_start || (wait_count != `PMSC_WAIT_ZERO);

  pmsc_clk_div u_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // Settling count chosen by the wait field
  always @* begin
    case (system_control_one[`PMSC_C1_STS_HI:`PMSC_C1_STS_LO])
      3'h0:    wait_load = `PMSC_W0;
      3'h1:    wait_load = `PMSC_W1;
      3'h2:    wait_load = `PMSC_W2;
      3'h3:    wait_load = `PMSC_W3;
      3'h4:    wait_load = `PMSC_W4;
      3'h5:    wait_load = `PMSC_W5;
      3'h6:    wait_load = `PMSC_W6;
      default: wait_load = `PMSC_W7;
    endcase
  end

  // Mode transition on sleep or wake; a sleep in the same
  // cycle as a wake wins, and a sleep outside active or
  // subactive is ignored
  always @* begin
    next_mode   = power_mode;
    next_direct = 1'b0;
    if (sleep_exec && in_active) begin
      if (direct_transfer_flag && sby && !low_speed_cpu_flag) begin
        next_mode   = medium_speed_flag ? `PMSC_M_ACT_MED : `PMSC_M_ACT_HI;
        next_direct = (next_mode != power_mode);
      end else if (direct_transfer_flag && !sby && low_speed_cpu_flag) begin
        next_mode   = `PMSC_M_SUBACT;
        next_direct = 1'b1;
      end else if (!sby) begin
        next_mode = `PMSC_M_SLEEP;
      end else begin
        next_mode = low_speed_cpu_flag ? `PMSC_M_WATCH : `PMSC_M_STANDBY;
      end
    end else if (sleep_exec && in_subact) begin
      if (direct_transfer_flag && sby && timer_a_watch_select && !low_speed_cpu_flag) begin
        next_mode   = medium_speed_flag ? `PMSC_M_ACT_MED : `PMSC_M_ACT_HI;
        next_direct = 1'b1;
      end else if (!sby) begin
        next_mode = `PMSC_M_SUBSLEEP;
      end else begin
        next_mode = `PMSC_M_WATCH;
      end
    end else if (wake_req) begin
      case (power_mode)
        `PMSC_M_SLEEP, `PMSC_M_STANDBY:
          next_mode = medium_speed_flag ? `PMSC_M_ACT_MED : `PMSC_M_ACT_HI;
        `PMSC_M_SUBSLEEP:
          next_mode = `PMSC_M_SUBACT;
        `PMSC_M_WATCH:
          next_mode = low_speed_cpu_flag ? `PMSC_M_SUBACT :
                      (medium_speed_flag ? `PMSC_M_ACT_MED : `PMSC_M_ACT_HI);
        default:
          next_mode = power_mode;
      endcase
    end
  end

  // Noise strobe picks the fast or slow tap
  always @* begin
    if (system_control_two[`PMSC_C2_NES]) begin
      next_tick = tick[`PMSC_TAP4];
    end else begin
      next_tick = tick[`PMSC_TAP16];
    end
  end

  // CPU clock enable per mode, held off during settling
  always @* begin
    case (system_control_one[`PMSC_C1_MA_HI:`PMSC_C1_MA_LO])
      2'h0:    next_clk_en = tick[`PMSC_TAP16];
      2'h1:    next_clk_en = tick[`PMSC_TAP32];
      2'h2:    next_clk_en = tick[`PMSC_TAP64];
      default: next_clk_en = tick[`PMSC_TAP128];
    endcase
    if (next_mode != `PMSC_M_ACT_MED) begin
      // Full-speed clock only in high-speed active
      next_clk_en = (next_mode == `PMSC_M_ACT_HI);
    end
    if (settling) begin
      next_clk_en = 1'b0;
    end
  end

  // Control registers; reserved bits keep their fixed values
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      system_control_one <= `PMSC_C1_RESET;
      system_control_two <= `PMSC_C2_RESET;
    end else begin
      if (wr_ctrl1) begin
        system_control_one <= (reg_wdata & `PMSC_C1_WMASK) |
                              (`PMSC_C1_RESET & ~`PMSC_C1_WMASK);
      end
      if (wr_ctrl2) begin
        system_control_two <= (reg_wdata & `PMSC_C2_WMASK) |
                              (`PMSC_C2_RESET & ~`PMSC_C2_WMASK);
      end
    end
  end

  // Mode and settling wait counter
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_mode    <= `PMSC_M_ACT_HI;
      wait_count    <= `PMSC_WAIT_ZERO;
      settling_busy <= 1'b0;
    end else begin
      power_mode <= next_mode;
      if (settle_start) begin
        wait_count <= wait_load;
      end else if (wait_count != `PMSC_WAIT_ZERO) begin
        wait_count <= wait_count - `PMSC_WAIT_ONE;
      end
      settling_busy <= settle_start || (wait_count > `PMSC_WAIT_ONE);
    end
  end

  // Direct transition flag; a set in the clearing cycle wins
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      direct_transition_flag <= 1'b0;
    end else if (next_direct) begin
      direct_transition_flag <= 1'b1;
    end else if (clr_flag) begin
      direct_transition_flag <= 1'b0;
    end
  end

  // Registered noise strobe and CPU clock enable
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      noise_sample_tick <= 1'b0;
      cpu_clk_en        <= 1'b0;
    end else begin
      noise_sample_tick <= next_tick;
      cpu_clk_en        <= next_clk_en;
    end
  end

  // Read data stands one cycle after the strobe, idle otherwise
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `PMSC_RDATA_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        `PMSC_OFS_CTRL1:  reg_rdata <= system_control_one;
        `PMSC_OFS_CTRL2:  reg_rdata <= system_control_two;
        `PMSC_OFS_STATUS: reg_rdata <= {4'h0, direct_transition_flag, power_mode};
        default:          reg_rdata <= `PMSC_RDATA_IDLE;
      endcase
    end else begin
      reg_rdata <= `PMSC_RDATA_IDLE;
    end
  end
endmodule // pmsc_power_ctrl
`default_nettype wire

// >>> design/pmsc_regs.vh
/*
  Register offsets, field positions, reset values, mode codes and
  standby wait counts for the power-mode and sleep control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PMSC_REGS_VH
`define PMSC_REGS_VH
// Register offsets
`define PMSC_OFS_CTRL1     8'hF0
`define PMSC_OFS_CTRL2     8'hF1
`define PMSC_OFS_STATUS    8'hF2
// Control one fields
`define PMSC_C1_SBY        7
`define PMSC_C1_STS_HI     6
`define PMSC_C1_STS_LO     4
`define PMSC_C1_LOW_SPEED_CPU_FLAG       3
`define PMSC_C1_MA_HI      1
`define PMSC_C1_MA_LO      0
`define PMSC_C1_RESET      8'h07
`define PMSC_C1_WMASK      8'hFB
// Control two fields
`define PMSC_C2_NES        4
`define PMSC_C2_DT         3
`define PMSC_C2_MS         2
`define PMSC_C2_SA_HI      1
`define PMSC_C2_SA_LO      0
`define PMSC_C2_RESET      8'hF0
`define PMSC_C2_WMASK      8'h1F
// Status fields
`define PMSC_ST_DTF        3
// Mode codes
`define PMSC_M_ACT_HI      3'h0
`define PMSC_M_ACT_MED     3'h1
`define PMSC_M_SUBACT      3'h2
`define PMSC_M_SLEEP       3'h3
`define PMSC_M_SUBSLEEP    3'h4
`define PMSC_M_STANDBY     3'h5
`define PMSC_M_WATCH       3'h6
// Standby wait counts in states
`define PMSC_W0            18'h02000
`define PMSC_W1            18'h04000
`define PMSC_W2            18'h08000
`define PMSC_W3            18'h10000
`define PMSC_W4            18'h20000
`define PMSC_W5            18'h00002
`define PMSC_W6            18'h00008
`define PMSC_W7            18'h00010
// Divider widths and taps
`define PMSC_DIV_W         7
`define PMSC_DIV_ONE       7'h01
`define PMSC_DIV_ZERO      7'h00
`define PMSC_TAP16         3
`define PMSC_TAP4          1
`define PMSC_TAP32         4
`define PMSC_TAP64         5
`define PMSC_TAP128        6
// Settling counter end points and idle read data
`define PMSC_WAIT_ZERO     18'h00000
`define PMSC_WAIT_ONE      18'h00001
`define PMSC_RDATA_IDLE    8'h00
`endif

// >>> verification/pmsc_chk_assertions.sv
/* Port checker for the power-mode control block.
   Assumes one clock and that register writes are seen on the port. */
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_regs.vh"
module pmsc_chk (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       sleep_exec,
  input wire logic       timer_a_watch_select,
  input wire logic [2:0] power_mode,
  input wire logic       cpu_clk_en,
  input wire logic       noise_sample_tick,
  input wire logic       settling_busy,
  input wire logic       direct_transition_flag
);
  logic [7:0] c1;
  logic [7:0] c2;
  // Sleep taken in active or subactive
  wire act = sleep_exec && power_mode < `PMSC_M_SUBACT;
  wire sub = sleep_exec && power_mode == `PMSC_M_SUBACT;
  wire dir = sub && c1[7] && c2[3] && timer_a_watch_select && !c1[3];
  // Shadow copies of both control registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      c1 <= `PMSC_C1_RESET;
      c2 <= `PMSC_C2_RESET;
    end else if (reg_wr && reg_addr == `PMSC_OFS_CTRL1) begin
      c1 <= reg_wdata & `PMSC_C1_WMASK | 8'h04;
    end else if (reg_wr && reg_addr == `PMSC_OFS_CTRL2) begin
      c2 <= reg_wdata & `PMSC_C2_WMASK | 8'hE0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_slp; act && !c1[7] && !c2[3] |=> power_mode == `PMSC_M_SLEEP; endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  property p_sub; sub && !c1[7] && !c2[3] |=> power_mode == `PMSC_M_SUBSLEEP; endproperty
  a_sub: assert property (p_sub) else $error("no subsleep");
  property p_sby; act && c1[7] && !c2[3] |=> power_mode inside {3'h5, 3'h6}; endproperty
  a_sby: assert property (p_sby) else $error("no standby");
  property p_wch; sub && c1[7] && !c2[3] |=> power_mode == `PMSC_M_WATCH; endproperty
  a_wch: assert property (p_wch) else $error("no watch");
  property p_hi; dir && !c2[2] |=> power_mode == 3'h0 && direct_transition_flag; endproperty
  a_hi: assert property (p_hi) else $error("no direct high");
  property p_med; dir && c2[2] |=> power_mode == 3'h1 && direct_transition_flag; endproperty
  a_med: assert property (p_med) else $error("no direct medium");
  property p_nse; noise_sample_tick |=> !noise_sample_tick [*3]; endproperty
  a_nse: assert property (p_nse) else $error("noise tick early");
  property p_wt; settling_busy |-> !cpu_clk_en; endproperty
  a_wt: assert property (p_wt) else $error("clock during wait");
  property p_dts;
    act && c2[3] && !c1[7] && c1[3] |=> power_mode == `PMSC_M_SUBACT && direct_transition_flag;
  endproperty
  a_dts: assert property (p_dts) else $error("no direct subactive flag");
  property p_nof; !sleep_exec && !direct_transition_flag |=> !direct_transition_flag; endproperty
  a_nof: assert property (p_nof) else $error("flag set without sleep");
  property p_mck; power_mode == `PMSC_M_ACT_MED && cpu_clk_en |=> !cpu_clk_en [*8]; endproperty
  a_mck: assert property (p_mck) else $error("medium clock too fast");
endmodule // pmsc_chk
bind pmsc_power_ctrl pmsc_chk u_chk (
  .ref_clk                (ref_clk),
  .reset_n                (reset_n),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_wr                 (reg_wr),
  .sleep_exec             (sleep_exec),
  .timer_a_watch_select   (timer_a_watch_select),
  .power_mode             (power_mode),
  .cpu_clk_en             (cpu_clk_en),
  .noise_sample_tick      (noise_sample_tick),
  .settling_busy          (settling_busy),
  .direct_transition_flag (direct_transition_flag)
);
`default_nettype wire

// >>> verification/power_mode_sleep_control_bench.sv
/* Bench for the power-mode control block.
   Assumes the register map header is on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_regs.vh"
module power_mode_sleep_control_bench;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sleep_exec = 1'b0;
  logic       wake_req = 1'b0;
  logic       timer_a_watch_select = 1'b0;
  wire  [7:0] reg_rdata;
  wire  [2:0] power_mode;
  wire        cpu_clk_en;
  wire        noise_sample_tick;
  wire        settling_busy;
  wire        direct_transition_flag;
  int         failures = 0;
  int         compares = 0;
  int         n;
  int         i;
  int         k;
  logic [1:0] ma;
  logic       ns;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  pmsc_power_ctrl dut (
    .ref_clk                (ref_clk),
    .reset_n                (reset_n),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .sleep_exec             (sleep_exec),
    .wake_req               (wake_req),
    .timer_a_watch_select   (timer_a_watch_select),
    .power_mode             (power_mode),
    .cpu_clk_en             (cpu_clk_en),
    .noise_sample_tick      (noise_sample_tick),
    .settling_busy          (settling_busy),
    .direct_transition_flag (direct_transition_flag)
  );
  task summarize;
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Settling wait per wait code
  function int wait_of(input logic [2:0] c);
    return c == 3'h5 ? 2 : c == 3'h6 ? 8 : c == 3'h7 ? 16 : 8192 << c;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  // Sleep or wake pulse; mode 7 skips the mode check
  task pulse(input bit w, input logic [2:0] e);
    @(posedge ref_clk);
    sleep_exec <= !w;
    wake_req <= w;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    wake_req <= 1'b0;
    #1 if (e != 3'h7) chk("power_mode", power_mode, e);
  endtask
  // Cycles between two pulses of the noise tick or the cpu enable
  task gap(input bit s, output int g);
    int t0;
    t0 = -1;
    g = 0;
    for (k = 0; k < 300 && g == 0; k++) begin
      @(posedge ref_clk);
      #1 if ((s ? noise_sample_tick : cpu_clk_en) === 1'b1) begin
        if (t0 >= 0) g = k - t0;
        t0 = k;
      end
    end
    if (g == 0) chk("pulse timeout", 0, 1);
    if (g == 0) summarize;
  endtask
  task settle(input logic [2:0] c);
    wr(`PMSC_OFS_CTRL1, {1'b1, c, 4'h0});
    pulse(0, `PMSC_M_STANDBY);
    pulse(1, 3'h7);
    n = 0;
    repeat (wait_of(c) + 9) @(posedge ref_clk) n += settling_busy;
    chk("wait", n >= wait_of(c) - 2 && n <= wait_of(c) + 1, 1);
    #1 chk("mode after wait", power_mode, `PMSC_M_ACT_HI);
  endtask
  initial begin
    i = $urandom(8);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`PMSC_OFS_CTRL1, 8'h07);
    rd(`PMSC_OFS_CTRL2, 8'hF0);
    rd(8'h10, 8'h00);
    for (i = 5; i < 10; i++) settle(i[2:0]);
    for (i = 0; i < 5; i++) begin
      ma = i == 4 ? 2'h3 : 2'($urandom);
      ns = 1'($urandom);
      wr(`PMSC_OFS_CTRL1, {6'h00, ma});
      wr(`PMSC_OFS_CTRL2, {3'h0, ns, 4'h4});
      pulse(0, `PMSC_M_SLEEP);
      pulse(1, `PMSC_M_ACT_MED);
      gap(0, n);
      chk("cpu_clk_en period", n, 16 << ma);
      gap(1, n);
      chk("noise period", n, ns ? 4 : 16);
    end
    wr(`PMSC_OFS_CTRL1, 8'h08);
    wr(`PMSC_OFS_CTRL2, 8'h08);
    pulse(0, `PMSC_M_SUBACT);
    rd(`PMSC_OFS_STATUS, 8'h0A);
    wr(`PMSC_OFS_STATUS, 8'h00);
    wr(`PMSC_OFS_CTRL2, 8'h00);
    rd(`PMSC_OFS_STATUS, 8'h02);
    rd(`PMSC_OFS_CTRL2, 8'hE0);
    pulse(0, `PMSC_M_SUBSLEEP);
    pulse(1, `PMSC_M_SUBACT);
    wr(`PMSC_OFS_CTRL1, 8'h88);
    pulse(0, `PMSC_M_WATCH);
    pulse(1, `PMSC_M_SUBACT);
    @(posedge ref_clk) timer_a_watch_select <= 1'b1;
    wr(`PMSC_OFS_CTRL1, 8'h80);
    wr(`PMSC_OFS_CTRL2, 8'h08);
    pulse(0, `PMSC_M_ACT_HI);
    chk("direct flag", direct_transition_flag, 1);
    wr(`PMSC_OFS_CTRL1, 8'h08);
    wr(`PMSC_OFS_CTRL2, 8'h0C);
    pulse(0, `PMSC_M_SUBACT);
    wr(`PMSC_OFS_CTRL1, 8'h80);
    pulse(0, `PMSC_M_ACT_MED);
    // Mid-run reset returns registers, flag and mode to reset values
    @(posedge ref_clk) reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`PMSC_OFS_CTRL2, 8'hF0);
    rd(`PMSC_OFS_STATUS, 8'h00);
    summarize;
  end
endmodule // power_mode_sleep_control_bench
`default_nettype wire
